// [core/ear_top.sv]
`timescale 1ns/1ps
// How it works
// R1 - low ten instruction bits give the in-page offset, 1024-word pages
// R2 - bit 10 picks page zero or the current page
// R3 - upper address bits come from memory address register or zero
// R4 - bit 15 direct/indirect, from instruction or from address word
// R5 - indirect words chain on bit 15 with no level limit
// R6 - from third indirect level, pending interrupt aborts for restart
// R7 - split mode adds base offset to data addresses 2 through 1023
// R8 - split mode relocates every base-page reference except locations 0 and 1
// R9 - software keeps code and jumps off the base page in split mode
// R10 - locations 0 and 1 are the two accumulators
// R11 - interrupt vectors sit at fixed base-page locations
// R12 - writes to absent memory are dropped
// R13 - reads of absent memory return all ones, no parity error
// R14 - protected absent memory raises memory protect interrupt
// R15 - 32k word space, 32 pages of 2000 octal words
// R16 - split mode sends data accesses to the separate data space
// R17 - two-word references to base page are relocated too
// R18 - effective address and space flag go out with each operand
module ear_top import ear_pkg::*; (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        start_i,
  input  wire ear_req_t    req_i,
  input  wire logic [14:0] instr_addr_i,
  input  wire logic        code_data_split_mode_i,
  input  wire logic [14:0] base_offset_i,
  input  wire logic        irq_pending_i,
  input  wire ear_acc_t    acc_i,
  input  wire logic [2:0]  vec_class_i,
  input  wire logic [5:0]  vec_sc_i,
  input  wire logic        mem_ack_i,
  input  wire logic [15:0] mem_rdata_i,
  input  wire logic        mem_exists_i,
  input  wire logic        mem_protected_i,
  output logic             busy_o,
  output logic             done_o,
  output logic             abort_o,
  output logic [14:0]      ea_o,
  output logic             ea_data_space_o,
  output logic [15:0]      rdata_o,
  output logic [14:0]      vector_addr_o,
  output logic             mem_req_o,
  output logic [14:0]      mem_addr_o,
  output logic             mem_space_o,
  output logic             mem_we_o,
  output logic [15:0]      mem_wdata_o,
  output logic             acc_we_o,
  output logic             acc_sel_o,
  output logic [15:0]      acc_wdata_o,
  output logic             prot_irq_o
);

  typedef enum logic [1:0] {S_IDLE, S_PTR, S_OPND} ear_st_t;

  ear_st_t     state_reg;
  logic [1:0]  level_reg;
  logic [1:0]  level_next;
  logic        go_reg;
  logic [14:0] go_addr_reg;
  logic        go_we_reg;
  logic        wr_reg;
  logic [15:0] wdata_reg;
  logic        port_done;
  logic [15:0] port_rdata;
  logic [14:0] first_raw;
  logic        first_ind;
  logic        split;

  // ----------------------------------------
  // first address
  // ----------------------------------------
  assign split = code_data_split_mode_i;

  always_comb begin
    if (req_i.two_word) begin
      first_raw = req_i.addr_word[ADDR_W-1:0]; // R17
      first_ind = req_i.addr_word[IND_BIT]; // R4
    end else begin
      // page zero forces the upper bits clear
      first_raw[OFFS_W-1:0] = req_i.instr[OFFS_W-1:0]; // R1
      first_raw[ADDR_W-1:PAGE_BIT] = req_i.instr[PAGE_BIT] ?
        instr_addr_i[ADDR_W-1:PAGE_BIT] : 5'h00; // R2 R3 R15
      first_ind = req_i.instr[IND_BIT]; // R4
    end
  end

  // saturates: depth past three only matters as "deep"
  assign level_next = (level_reg == DEEP_LVL) ? level_reg
                                              : 2'(level_reg + 2'h1);

  // ----------------------------------------
  // chain sequencing
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= S_IDLE;
      level_reg <= 2'h0;
      busy_o    <= 1'b0;
      abort_o   <= 1'b0;
    end else begin
      abort_o <= 1'b0;
      case (state_reg)
        S_IDLE: if (start_i) begin
          level_reg <= 2'h0;
          busy_o    <= 1'b1;
          state_reg <= first_ind ? S_PTR : S_OPND;
        end
        S_PTR: if (port_done) begin
          if (port_rdata[IND_BIT] && level_next == DEEP_LVL &&
              irq_pending_i) begin
            abort_o   <= 1'b1; // R6
            busy_o    <= 1'b0;
            state_reg <= S_IDLE;
          end else begin
            level_reg <= level_next;
            if (!port_rdata[IND_BIT]) state_reg <= S_OPND; // R5
          end
        end
        S_OPND: if (port_done) begin
          busy_o    <= 1'b0;
          state_reg <= S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // access issue
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      go_reg      <= 1'b0;
      go_addr_reg <= 15'h0000;
      go_we_reg   <= 1'b0;
      wr_reg      <= 1'b0;
      wdata_reg   <= 16'h0000;
    end else begin
      go_reg <= 1'b0;
      if (state_reg == S_IDLE && start_i) begin
        go_reg      <= 1'b1;
        go_addr_reg <= ear_reloc(first_raw, base_offset_i, split); // R7 R8
        go_we_reg   <= first_ind ? 1'b0 : req_i.write;
        wr_reg      <= req_i.write;
        wdata_reg   <= req_i.wdata;
      end else if (state_reg == S_PTR && port_done &&
                   !(port_rdata[IND_BIT] && level_next == DEEP_LVL &&
                     irq_pending_i)) begin
        // pointer words are data and are relocated like any other
        go_reg      <= 1'b1; // R5
        go_addr_reg <= ear_reloc(port_rdata[ADDR_W-1:0],
                                 base_offset_i, split); // R7
        go_we_reg   <= port_rdata[IND_BIT] ? 1'b0 : wr_reg;
      end
    end
  end

  // ----------------------------------------
  // results
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      done_o          <= 1'b0;
      ea_o            <= 15'h0000;
      ea_data_space_o <= 1'b0;
      rdata_o         <= 16'h0000;
    end else begin
      done_o <= 1'b0;
      if (state_reg == S_OPND && port_done) begin
        done_o          <= 1'b1;
        ea_o            <= go_addr_reg; // R18
        ea_data_space_o <= split; // R16
        rdata_o         <= port_rdata;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      vector_addr_o <= VEC_PWR;
    end else begin
      vector_addr_o <= ear_vector(vec_class_i, vec_sc_i); // R11
    end
  end

  // ----------------------------------------
  // memory and accumulator port
  // ----------------------------------------
  ear_mem_port u_port (
    .clk_i           (clk_i),
    .rst_i           (rst_i),
    .go_i            (go_reg),
    .addr_i          (go_addr_reg),
    .space_i         (split), // R16
    .we_i            (go_we_reg),
    .wdata_i         (wdata_reg),
    .acc_i           (acc_i),
    .mem_ack_i       (mem_ack_i),
    .mem_rdata_i     (mem_rdata_i),
    .mem_exists_i    (mem_exists_i),
    .mem_protected_i (mem_protected_i),
    .done_o          (port_done),
    .rdata_o         (port_rdata),
    .mem_req_o       (mem_req_o),
    .mem_addr_o      (mem_addr_o),
    .mem_space_o     (mem_space_o),
    .mem_we_o        (mem_we_o),
    .mem_wdata_o     (mem_wdata_o),
    .acc_we_o        (acc_we_o),
    .acc_sel_o       (acc_sel_o),
    .acc_wdata_o     (acc_wdata_o),
    .prot_irq_o      (prot_irq_o)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_page_zero_sel: assert property ( // R2
    state_reg == S_IDLE && start_i && !req_i.two_word &&
    !req_i.instr[PAGE_BIT] && !split
    |=> go_addr_reg == {5'h00, $past(req_i.instr[9:0])}
  ) else $error("page zero address wrong");
  chk_current_page: assert property ( // R3
    state_reg == S_IDLE && start_i && !req_i.two_word &&
    req_i.instr[PAGE_BIT] && !split
    |=> go_addr_reg[14:10] == $past(instr_addr_i[14:10]) &&
        go_addr_reg[9:0] == $past(req_i.instr[9:0])
  ) else $error("current page address wrong");
  chk_indirect_start: assert property ( // R4
    state_reg == S_IDLE && start_i && !req_i.two_word &&
    req_i.instr[IND_BIT] |=> state_reg == S_PTR && go_reg && !go_we_reg
  ) else $error("indirect bit not honoured");
  chk_eau_direct: assert property ( // R4
    state_reg == S_IDLE && start_i && req_i.two_word &&
    !req_i.addr_word[IND_BIT] && !split
    |=> state_reg == S_OPND && go_addr_reg == $past(req_i.addr_word[14:0])
  ) else $error("two-word direct address wrong");
  chk_base_relocate: assert property ( // R8
    state_reg == S_IDLE && start_i && !req_i.two_word && split &&
    !req_i.instr[PAGE_BIT] && req_i.instr[9:0] >= 10'h002
    |=> go_addr_reg == 15'($past(req_i.instr[9:0]) + $past(base_offset_i))
  ) else $error("base offset not added");
  chk_acc_unshifted: assert property ( // R7
    state_reg == S_IDLE && start_i && !req_i.two_word && split &&
    !req_i.instr[PAGE_BIT] && req_i.instr[9:0] < 10'h002
    |=> go_addr_reg == {5'h00, $past(req_i.instr[9:0])}
  ) else $error("accumulator address relocated");
  chk_abort_deep: assert property ( // R6
    abort_o |-> $past(level_reg) >= 2'h2 && !busy_o && state_reg == S_IDLE
  ) else $error("abort before third level");
  chk_chain_follow: assert property ( // R5
    state_reg == S_PTR && port_done && port_rdata[IND_BIT] && !irq_pending_i
    |=> state_reg == S_PTR && go_reg && !go_we_reg
  ) else $error("indirect chain stopped");
  chk_vector_prot: assert property ( // R11
    vec_class_i == VC_PROT |=> vector_addr_o == VEC_PROT
  ) else $error("protect vector wrong");

  cov_direct_done: cover property (
    state_reg == S_OPND ##1 state_reg == S_OPND [*1] ##[1:20] done_o);
  cov_deep_abort: cover property (abort_o);
  cov_split_reloc: cover property (done_o && ea_data_space_o && ea_o > 15'h0001);

endmodule

// [core/ear_pkg.sv]
package ear_pkg;

  // ----------------------------------------
  // address layout
  // ----------------------------------------
  localparam int          ADDR_W   = 15;
  localparam int          OFFS_W   = 10;
  localparam int          PAGE_BIT = 10;
  localparam int          IND_BIT  = 15;
  localparam logic [14:0] ACC_A_LOC = 15'h0000;
  localparam logic [14:0] ACC_B_LOC = 15'h0001;
  localparam logic [14:0] REL_LO    = 15'h0002;
  localparam logic [14:0] REL_HI    = 15'h03ff;
  localparam logic [15:0] NX_WORD   = 16'hffff;
  localparam logic [1:0]  DEEP_LVL  = 2'h3;

  // ----------------------------------------
  // interrupt vectors
  // ----------------------------------------
  localparam logic [2:0]  VC_PWR    = 3'h0;
  localparam logic [2:0]  VC_PAR    = 3'h1;
  localparam logic [2:0]  VC_TBG    = 3'h2;
  localparam logic [2:0]  VC_PROT   = 3'h3;
  localparam logic [2:0]  VC_UNIMPL = 3'h4;
  localparam logic [2:0]  VC_VIRT   = 3'h5;
  localparam logic [2:0]  VC_SEG    = 3'h6;
  localparam logic [2:0]  VC_CARD   = 3'h7;
  localparam logic [14:0] VEC_PWR    = 15'h0004;
  localparam logic [14:0] VEC_PAR    = 15'h0005;
  localparam logic [14:0] VEC_TBG    = 15'h0006;
  localparam logic [14:0] VEC_PROT   = 15'h0007;
  localparam logic [14:0] VEC_UNIMPL = 15'h0008;
  localparam logic [14:0] VEC_VIRT   = 15'h000a;
  localparam logic [14:0] VEC_SEG    = 15'h000b;
  localparam logic [5:0]  SC_LO      = 6'h10;

  typedef struct packed {
    logic [15:0] instr;
    logic [15:0] addr_word;
    logic        two_word;
    logic        write;
    logic [15:0] wdata;
  } ear_req_t;

  typedef struct packed {
    logic [15:0] a;
    logic [15:0] b;
  } ear_acc_t;

  function automatic logic [14:0] ear_vector(input logic [2:0] cls,
                                             input logic [5:0] sc);
    case (cls)
      VC_PWR:    return VEC_PWR;
      VC_PAR:    return VEC_PAR;
      VC_TBG:    return VEC_TBG;
      VC_PROT:   return VEC_PROT;
      VC_UNIMPL: return VEC_UNIMPL;
      VC_VIRT:   return VEC_VIRT;
      VC_SEG:    return VEC_SEG;
      default:   return {9'h000, (sc < SC_LO) ? SC_LO : sc};
    endcase
  endfunction

  // in split mode, base-page data references 2 through 1023 shift by the base offset
  function automatic logic [14:0] ear_reloc(input logic [14:0] a,
                                            input logic [14:0] base,
                                            input logic        split);
    if (split && a >= REL_LO && a <= REL_HI)
      return 15'(a + base);
    return a;
  endfunction

endpackage

// [core/ear_mem_port.sv]
`timescale 1ns/1ps
module ear_mem_port import ear_pkg::*; (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        go_i,
  input  wire logic [14:0] addr_i,
  input  wire logic        space_i,
  input  wire logic        we_i,
  input  wire logic [15:0] wdata_i,
  input  wire ear_acc_t    acc_i,
  input  wire logic        mem_ack_i,
  input  wire logic [15:0] mem_rdata_i,
  input  wire logic        mem_exists_i,
  input  wire logic        mem_protected_i,
  output logic             done_o,
  output logic [15:0]      rdata_o,
  output logic             mem_req_o,
  output logic [14:0]      mem_addr_o,
  output logic             mem_space_o,
  output logic             mem_we_o,
  output logic [15:0]      mem_wdata_o,
  output logic             acc_we_o,
  output logic             acc_sel_o,
  output logic [15:0]      acc_wdata_o,
  output logic             prot_irq_o
);

  typedef enum logic [1:0] {P_IDLE, P_CHECK, P_WAIT} ear_pst_t;
  ear_pst_t state_reg;

  // ----------------------------------------
  // sequencing
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= P_IDLE;
    end else begin
      case (state_reg)
        P_IDLE:  if (go_i && addr_i > ACC_B_LOC) state_reg <= P_CHECK;
        P_CHECK: state_reg <= mem_exists_i ? P_WAIT : P_IDLE;
        P_WAIT:  if (mem_ack_i) state_reg <= P_IDLE;
        default: state_reg <= P_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // memory side
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mem_req_o   <= 1'b0;
      mem_addr_o  <= 15'h0000;
      mem_space_o <= 1'b0;
      mem_we_o    <= 1'b0;
      mem_wdata_o <= 16'h0000;
    end else begin
      if (state_reg == P_IDLE && go_i) begin
        mem_addr_o  <= addr_i;
        mem_space_o <= space_i;
        mem_we_o    <= we_i;
        mem_wdata_o <= wdata_i;
      end
      // absent locations never see a request, so writes die here
      if (state_reg == P_CHECK && mem_exists_i)
        mem_req_o <= 1'b1; // R12
      else if (state_reg == P_WAIT && mem_ack_i)
        mem_req_o <= 1'b0;
    end
  end

  // ----------------------------------------
  // answers
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      done_o      <= 1'b0;
      rdata_o     <= 16'h0000;
      acc_we_o    <= 1'b0;
      acc_sel_o   <= 1'b0;
      acc_wdata_o <= 16'h0000;
      prot_irq_o  <= 1'b0;
    end else begin
      done_o     <= 1'b0;
      acc_we_o   <= 1'b0;
      prot_irq_o <= 1'b0;
      case (state_reg)
        P_IDLE: if (go_i && addr_i <= ACC_B_LOC) begin
          done_o      <= 1'b1; // R10
          acc_sel_o   <= addr_i[0];
          acc_we_o    <= we_i;
          acc_wdata_o <= wdata_i;
          if (!we_i) rdata_o <= addr_i[0] ? acc_i.b : acc_i.a;
        end
        P_CHECK: if (!mem_exists_i) begin
          done_o     <= 1'b1;
          prot_irq_o <= mem_protected_i; // R14
          if (!mem_we_o) rdata_o <= NX_WORD; // R13
        end
        P_WAIT: if (mem_ack_i) begin
          done_o <= 1'b1;
          if (!mem_we_o) rdata_o <= mem_rdata_i;
        end
        default: done_o <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_nx_write_drop: assert property ( // R12
    state_reg == P_CHECK && mem_we_o && !mem_exists_i |=> !mem_req_o
  ) else $error("write to absent location reached memory");
  chk_nx_read_ones: assert property ( // R13
    state_reg == P_CHECK && !mem_we_o && !mem_exists_i
    |=> done_o && rdata_o == NX_WORD
  ) else $error("absent read did not return all ones");
  chk_nx_protect: assert property ( // R14
    state_reg == P_CHECK && !mem_exists_i && mem_protected_i
    |=> prot_irq_o
  ) else $error("protect interrupt missing");
  chk_acc_b_read: assert property ( // R10
    state_reg == P_IDLE && go_i && addr_i == ACC_B_LOC && !we_i
    |=> done_o && !mem_req_o && rdata_o == $past(acc_i.b)
  ) else $error("second accumulator read wrong");

endmodule

// [test/ear_mem_model.sv]
`timescale 1ns/1ps
module ear_mem_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  lat_i,
  input  wire logic        req_i,
  input  wire logic [14:0] addr_i,
  input  wire logic        space_i,
  input  wire logic        we_i,
  input  wire logic [15:0] wdata_i,
  output logic             ack_o,
  output logic [15:0]      rdata_o,
  output logic             exists_o,
  output logic             prot_o
);
  // ------------------------------
  // storage keyed by space and address
  // ------------------------------
  logic [15:0] mem [logic [15:0]];
  logic [3:0]  wait_reg;

  // top quarter absent, its upper half protected
  assign exists_o = addr_i < 15'h6000;
  assign prot_o   = addr_i >= 15'h7000;

  task automatic put(input logic sp, input logic [14:0] a,
                     input logic [15:0] v);
    mem[{sp, a}] = v;
  endtask

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_o    <= 1'b0;
      wait_reg <= 4'h0;
      rdata_o  <= 16'h5a5a;
    end else if (req_i && !ack_o && wait_reg == lat_i) begin
      ack_o    <= 1'b1;
      wait_reg <= 4'h0;
      rdata_o  <= mem.exists({space_i, addr_i}) ?
                  mem[{space_i, addr_i}] : 16'h0000;
      if (we_i && exists_o)
        mem[{space_i, addr_i}] = wdata_i;
    end else begin
      ack_o    <= 1'b0;
      wait_reg <= (req_i && !ack_o) ? wait_reg + 4'h1 : 4'h0;
      // released data line must never look valid
      rdata_o  <= ~rdata_o;
    end
  end
endmodule

// [test/ear_top_bench.sv]
`timescale 1ns/1ps
module ear_top_bench;
  import ear_pkg::*;
  typedef struct packed {
    logic        abort;
    logic        write;
    logic [14:0] ea;
    logic        space;
    logic [15:0] rdata;
  } ear_note_t;
  logic clk_i = 1'b0, rst_i = 1'b1, start_i = 1'b0;
  ear_req_t    req_i = '0;
  ear_acc_t    acc_i = '{16'h1357, 16'h2468};
  logic [14:0] instr_addr_i = '0, base_offset_i = 15'h0800;
  logic        code_data_split_mode_i = 1'b0, irq_pending_i = 1'b0;
  logic [2:0]  vec_class_i = '0;
  logic [5:0]  vec_sc_i = '0;
  logic [3:0]  lat = '0;
  logic        mem_ack_i, mem_exists_i, mem_protected_i;
  logic [15:0] mem_rdata_i, rdata_o, mem_wdata_o, acc_wdata_o;
  logic [14:0] ea_o, vector_addr_o, mem_addr_o;
  logic        busy_o, done_o, abort_o, ea_data_space_o, mem_req_o;
  logic        mem_space_o, mem_we_o, acc_we_o, acc_sel_o, prot_irq_o;
  ear_note_t   note_q[$], mon_n;
  logic [16:0] acc_q[$];
  logic [31:0] wr_q[$];
  logic [15:0] ref_mem [logic [15:0]];
  int          miscompares = 0, n_checks = 0, prot_seen = 0;
  integer      seed = 15803;
  logic [14:0] pc;
  logic        sp, irq;
  logic [14:0] vt [7] = '{15'h4, 15'h5, 15'h6, 15'h7, 15'h8, 15'ha, 15'hb};

  always #5 clk_i = ~clk_i;

  ear_top ear_top_inst (.clk_i, .rst_i, .start_i, .req_i, .instr_addr_i,
    .code_data_split_mode_i, .base_offset_i, .irq_pending_i, .acc_i,
    .vec_class_i, .vec_sc_i, .mem_ack_i, .mem_rdata_i, .mem_exists_i,
    .mem_protected_i, .busy_o, .done_o, .abort_o, .ea_o, .ea_data_space_o,
    .rdata_o, .vector_addr_o, .mem_req_o, .mem_addr_o, .mem_space_o,
    .mem_we_o, .mem_wdata_o, .acc_we_o, .acc_sel_o, .acc_wdata_o,
    .prot_irq_o);

  ear_mem_model ear_mem_model_inst (.clk_i, .rst_i, .lat_i(lat),
    .req_i(mem_req_o), .addr_i(mem_addr_o), .space_i(mem_space_o),
    .we_i(mem_we_o), .wdata_i(mem_wdata_o), .ack_o(mem_ack_i),
    .rdata_o(mem_rdata_i), .exists_o(mem_exists_i),
    .prot_o(mem_protected_i));

  // ------------------------------
  // checking helpers
  // ------------------------------
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  function automatic logic [14:0] rel(input logic [14:0] a);
    return (sp && a >= 15'h2 && a <= 15'h3ff) ? a + base_offset_i : a;
  endfunction

  function automatic logic [15:0] rd(input logic [14:0] a);
    if (a < 15'h2)
      return a[0] ? acc_i.b : acc_i.a;
    if (a >= 15'h6000)
      return 16'hffff;
    return ref_mem.exists({sp, a}) ? ref_mem[{sp, a}] : 16'h0000;
  endfunction

  task automatic put(input logic [14:0] a, input logic [15:0] v);
    ref_mem[{sp, a}] = v;
    ear_mem_model_inst.put(sp, a, v);
  endtask

  // ------------------------------
  // one operand access: note the outcome, then drive it
  // ------------------------------
  task automatic op(input logic tw, input logic [15:0] v,
                    input logic wr, input logic [15:0] wd);
    ear_note_t   n;
    logic [14:0] a;
    logic        ind;
    logic [15:0] w;
    int          lvl;
    int          k;
    n = '0;
    lvl = 0;
    k = 0;
    a = tw ? v[14:0] : {v[10] ? pc[14:10] : 5'h00, v[9:0]};
    ind = v[15];
    while (ind && !n.abort) begin
      w = rd(rel(a));
      lvl++;
      n.abort = w[15] && lvl == 3 && irq;
      a = w[14:0];
      ind = w[15];
    end
    n.ea = rel(a);
    n.space = sp;
    n.write = wr;
    n.rdata = rd(n.ea);
    if (!n.abort && wr && n.ea < 15'h2)
      acc_q.push_back({n.ea[0], wd});
    else if (!n.abort && wr && n.ea < 15'h6000) begin
      wr_q.push_back({sp, n.ea, wd});
      ref_mem[{sp, n.ea}] = wd;
    end
    note_q.push_back(n);
    @(posedge clk_i);
    start_i <= 1'b1;
    req_i <= '{tw ? 16'h0 : v, tw ? v : 16'h0, tw, wr, wd};
    instr_addr_i <= pc;
    code_data_split_mode_i <= sp;
    irq_pending_i <= irq;
    @(posedge clk_i);
    start_i <= 1'b0;
    @(negedge clk_i);
    check("busy", busy_o, 1);
    do
      @(negedge clk_i);
    while (!(done_o || abort_o) && ++k < 200);
    check("finish", k < 200, 1);
    check("busy", busy_o, 0);
    @(posedge clk_i);
  endtask

  // ------------------------------
  // output watcher
  // ------------------------------
  always @(posedge clk_i) begin
    if (done_o || abort_o) begin
      mon_n = note_q.size() ? note_q.pop_front() : '1;
      check("abort", abort_o, mon_n.abort);
      if (done_o) begin
        check("ea", ea_o, mon_n.ea);
        check("space", ea_data_space_o, mon_n.space);
        if (!mon_n.write)
          check("rdata", rdata_o, mon_n.rdata);
      end
    end
    if (acc_we_o)
      check("acc write", {acc_sel_o, acc_wdata_o},
            acc_q.size() ? acc_q.pop_front() : '1);
    if (mem_req_o && mem_ack_i && mem_we_o)
      check("mem write", {mem_space_o, mem_addr_o, mem_wdata_o},
            wr_q.size() ? wr_q.pop_front() : '1);
    if (prot_irq_o)
      prot_seen++;
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    test_done();
  end

  initial begin
    {pc, sp, irq} = {15'h5400, 2'b00};
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    put(15'h0155, 16'h1234);
    put(15'h5555, 16'h2222);
    put(15'h0200, 16'h8300);
    put(15'h0300, 16'h1000);
    put(15'h1000, 16'h7777);
    for (int i = 0; i < 3; i++)
      put(15'h0210 + 15'(i * 16), 16'h8220 + 16'(i * 16));
    put(15'h0240, 16'h1000);
    op(0, 16'h0155, 0, 0);
    op(0, 16'h0555, 0, 0);
    op(0, 16'h0555, 1, 16'hcafe);
    op(0, 16'h0555, 0, 0);
    for (int i = 0; i < 4; i++)
      op(0, 16'(i[0]), i[1], 16'hbee0 + 16'(i));
    $display("test direct done");
    op(0, 16'h8200, 0, 0);
    op(1, 16'h8200, 0, 0);
    for (int i = 0; i < 2; i++) begin
      irq = i[0];
      op(0, 16'h8210, 0, 0);
      op(0, 16'h8220, 0, 0);
    end
    irq = 1'b0;
    $display("test indirect done");
    sp = 1'b1;
    put(15'h0955, 16'h4321);
    op(1, 16'h0155, 0, 0);
    op(0, 16'h0155, 1, 16'h0f0f);
    foreach (vt[i])
      op(1, 16'(vt[i] * 15'h93), 0, 0);
    op(1, 16'h0001, 0, 0);
    op(0, 16'h0000, 0, 0);
    op(1, 16'h0400, 0, 0);
    $display("test split done");
    sp = 1'b0;
    op(1, 16'h6100, 0, 0);
    op(1, 16'h6100, 1, 16'h1111);
    check("prot", prot_seen, 0);
    op(1, 16'h7100, 0, 0);
    op(1, 16'h7100, 1, 16'h2222);
    @(negedge clk_i);
    check("prot", prot_seen, 2);
    $display("test absent done");
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_i);
      vec_class_i <= i[2:0];
      vec_sc_i <= 6'($random(seed));
      @(posedge clk_i);
      @(negedge clk_i);
      check("vector", vector_addr_o, vec_class_i == 3'h7 ?
            (vec_sc_i < 6'h10 ? 15'h10 : 15'(vec_sc_i)) :
            vt[vec_class_i]);
    end
    $display("test vectors done");
    for (int i = 0; i < 30; i++) begin
      pc = 15'($random(seed));
      if (pc < 15'h0400)
        pc += 15'h0400;
      sp = 1'($random(seed));
      base_offset_i <= 15'($random(seed)) & 15'h3fff;
      lat <= 4'($random(seed));
      @(posedge clk_i);
      op(0, 16'($random(seed)) & 16'h7fff, 1'($random(seed)),
         16'($random(seed)));
    end
    $display("test random done");
    test_done();
  end
endmodule
